// ===== verilog/swrt_tail.v
// swrt_tail.v: tail of the switch fundamental reset sequence.
// assumes srst_i is the switch fundamental reset and all inputs are
// synchronous to clk_i; eeprom loader and smbus reach the plain port.
`timescale 1ns/1ps
`include "swrt_consts.vh"

module swrt_tail #(
  parameter CFG_RDY_CYC = `SWRT_CFG_RDY_MS * `SWRT_CYC_PER_MS,
  parameter SUCC_CYC    = `SWRT_SUCC_MS * `SWRT_CYC_PER_MS,
  parameter EE_CYC      = `SWRT_EE_MS * `SWRT_CYC_PER_MS
) (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [3:0]  switch_mode_select_i,
  input  wire        boot_halt_i,
  input  wire        ee_done_i,
  input  wire        ee_err_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        cfg_req_i,
  input  wire        cfg_type0_i,
  output wire        cfg_retry_o,
  output wire        cfg_success_o,
  output wire        tlp_drop_o,
  output wire        fc_return_o,
  output reg  [15:0] link_retrain_o,
  output wire        normal_op_o,
  output wire        test_mode_o,
  output wire        ee_late_o
);

  // =============================================================
  // sequencer states, one-hot
  localparam [4:0] ST_LATCH = 5'h01;
  localparam [4:0] ST_EE    = 5'h02;
  localparam [4:0] ST_HALT  = 5'h04;
  localparam [4:0] ST_ULOCK = 5'h08;
  localparam [4:0] ST_RUN   = 5'h10;

  reg  [4:0]  st_q;
  reg  [4:0]  st_d;
  reg  [3:0]  mode_q;
  reg         halt_q;
  reg         unlock_q;
  reg  [3:0]  part_sel_q;
  reg  [3:0]  port_sel_q;
  reg  [1:0]  part_st_q [0:15];
  reg  [2:0]  port_md_q [0:15];
  reg  [23:0] tmr_q;
  reg         late_q;

  wire        normal;
  wire        multi;
  wire        ee;
  wire [1:0]  p0_st;
  wire [2:0]  p0_md;
  wire [2:0]  p2_md;
  wire [2:0]  ot_md;

  wire        wr_ctl  = reg_wr_i && (reg_addr_i == `SWRT_OFF_SWITCH_CONTROL_REG);
  wire        wr_pst  = reg_wr_i && (reg_addr_i == `SWRT_OFF_PART_CTL);
  wire        wr_pmd  = reg_wr_i && (reg_addr_i == `SWRT_OFF_PORT_CTL);
  wire        wr_lrt  = reg_wr_i && (reg_addr_i == `SWRT_OFF_LRETRAIN);
  wire        in_init = st_q[0] | st_q[1] | st_q[2] | st_q[3];
  // decode the strap itself in the latch cycle; mode_q is not yet loaded
  wire [3:0]  dec_mode = (st_q == ST_LATCH) ? switch_mode_select_i
                                            : mode_q;

  // =============================================================
  // mode decode
  swrt_mode_dec u_dec (
    .mode_i     (dec_mode),
    .normal_o   (normal),
    .multi_o    (multi),
    .ee_o       (ee),
    .part0_st_o (p0_st),
    .port0_md_o (p0_md),
    .port2_md_o (p2_md),
    .other_md_o (ot_md)
  );

  // =============================================================
  // sequencer next state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_LATCH: st_d = ee ? ST_EE : ST_HALT;
      ST_EE: begin
        if (ee_done_i || ee_err_i)
          st_d = ST_HALT;
      end
      ST_HALT: begin
        if (!halt_q)
          st_d = ST_ULOCK;
      end
      ST_ULOCK: st_d = ST_RUN;
      ST_RUN:   st_d = ST_RUN;
      default:  st_d = ST_LATCH;
    endcase
  end

  // =============================================================
  // mode latch and state; mode held until next reset
  always @(posedge clk_i) begin
    if (srst_i) begin
      st_q   <= ST_LATCH;
      mode_q <= 4'h0;
    end else begin
      st_q <= st_d;
      if (st_q == ST_LATCH)
        mode_q <= switch_mode_select_i;
    end
  end

  // =============================================================
  // switch control: halt and unlock flags
  // error set wins over a software clear in the same cycle
  always @(posedge clk_i) begin
    if (srst_i) begin
      halt_q   <= 1'b0;
      unlock_q <= 1'b0;
    end else begin
      if (st_q == ST_LATCH)
        halt_q <= boot_halt_i;
      else if (st_q == ST_EE && ee_err_i)
        halt_q <= 1'b1;
      else if (wr_ctl)
        halt_q <= reg_wdata_i[`SWRT_BIT_HALT];
      if (st_q == ST_ULOCK)
        unlock_q <= 1'b0;
      else if (wr_ctl)
        unlock_q <= reg_wdata_i[`SWRT_BIT_UNLOCK];
    end
  end

  // =============================================================
  // selectors for indexed partition and port access
  always @(posedge clk_i) begin
    if (srst_i) begin
      part_sel_q <= 4'h0;
      port_sel_q <= 4'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `SWRT_OFF_PART_SEL)
        part_sel_q <= reg_wdata_i[3:0];
      if (reg_wr_i && reg_addr_i == `SWRT_OFF_PORT_SEL)
        port_sel_q <= reg_wdata_i[3:0];
    end
  end

  // =============================================================
  // per-entry partition state and port mode storage
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_ent
      always @(posedge clk_i) begin
        if (srst_i) begin
          part_st_q[g] <= `SWRT_PST_DIS;
          port_md_q[g] <= `SWRT_PMD_DIS;
        end else if (st_q == ST_LATCH) begin
          // initial values applied from the decoded mode
          part_st_q[g] <= (g == 0) ? p0_st : `SWRT_PST_DIS;
          port_md_q[g] <= (g == 0) ? p0_md :
                          (g == 2) ? p2_md : ot_md;
        end else begin
          // only partition 0 writable unless multi-partition
          if (wr_pst && part_sel_q == g && (multi || g == 0))
            part_st_q[g] <= reg_wdata_i[1:0];
          if (wr_pmd && port_sel_q == g)
            port_md_q[g] <= reg_wdata_i[2:0];
        end
      end
    end
  endgenerate

  // =============================================================
  // retrain strobe fires in the cycle after the write
  always @(posedge clk_i) begin
    if (srst_i)
      link_retrain_o <= 16'h0000;
    else if (wr_lrt)
      link_retrain_o <= reg_wdata_i[15:0];
    else
      link_retrain_o <= 16'h0000;
  end

  // =============================================================
  // reset-to-ready timer; flags a late eeprom load
  always @(posedge clk_i) begin
    if (srst_i) begin
      tmr_q  <= 24'h000000;
      late_q <= 1'b0;
    end else begin
      if (tmr_q != 24'hffffff)
        tmr_q <= tmr_q + 24'h000001;
      if (st_q == ST_EE && tmr_q >= EE_CYC[23:0])
        late_q <= 1'b1;
    end
  end

  // =============================================================
  // configuration answers: retry while initialising, except non-type0 requests in halt are dropped with a credit return; never silent
  assign cfg_retry_o   = cfg_req_i && in_init &&
                         (cfg_type0_i || st_q != ST_HALT);
  assign cfg_success_o = cfg_req_i && !in_init;
  assign tlp_drop_o    = cfg_req_i && st_q == ST_HALT
                         && !cfg_type0_i;
  assign fc_return_o   = tlp_drop_o;
  assign normal_op_o   = st_q == ST_RUN;
  assign test_mode_o   = !normal;
  assign ee_late_o     = late_q;

  // =============================================================
  // read port, data one cycle after strobe; unmapped reads zero
  always @(posedge clk_i) begin
    if (srst_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        `SWRT_OFF_SWITCH_CONTROL_REG:
          reg_rdata_o <= {30'h0, unlock_q, halt_q};
        `SWRT_OFF_STATUS:
          reg_rdata_o <= {19'h0, late_q, test_mode_o, multi, ee,
                          st_q, mode_q};
        `SWRT_OFF_PART_SEL: reg_rdata_o <= {28'h0, part_sel_q};
        `SWRT_OFF_PART_CTL:
          reg_rdata_o <= {30'h0, part_st_q[part_sel_q]};
        `SWRT_OFF_PORT_SEL: reg_rdata_o <= {28'h0, port_sel_q};
        `SWRT_OFF_PORT_CTL:
          reg_rdata_o <= {29'h0, port_md_q[port_sel_q]};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end else
      reg_rdata_o <= 32'h00000000;
  end

endmodule // swrt_tail

// ===== verilog/swrt_consts.vh
// swrt_consts.vh: constants of the reset tail sequencer.
// assumes a 10 MHz core clock and a 32-bit plain register port.
`ifndef SWRT_CONSTS_VH
`define SWRT_CONSTS_VH

// =============================================================
// register offsets (byte addresses)
`define SWRT_OFF_SWITCH_CONTROL_REG     8'h00
`define SWRT_OFF_STATUS    8'h04
`define SWRT_OFF_PART_SEL  8'h08
`define SWRT_OFF_PART_CTL  8'h0c
`define SWRT_OFF_PORT_SEL  8'h10
`define SWRT_OFF_PORT_CTL  8'h14
`define SWRT_OFF_LRETRAIN  8'h18

// =============================================================
// switch control field positions
`define SWRT_BIT_HALT      0
`define SWRT_BIT_UNLOCK    1

// =============================================================
// partition state and port mode encodings
`define SWRT_PST_DIS       2'h0
`define SWRT_PST_ACT       2'h1
`define SWRT_PMD_DIS       3'h0
`define SWRT_PMD_DOWN      3'h1
`define SWRT_PMD_UP        3'h2
`define SWRT_PMD_UNATT     3'h5

// =============================================================
// switch mode values
`define SWRT_MD_SP         4'h0
`define SWRT_MD_SP_EE      4'h1
`define SWRT_MD_P0U        4'h8
`define SWRT_MD_P2U        4'h9
`define SWRT_MD_P0U_EE     4'ha
`define SWRT_MD_P2U_EE     4'hb
`define SWRT_MD_MP         4'hc
`define SWRT_MD_MP_EE      4'hd

// =============================================================
// timing in ms and the derived counts at 10 MHz (10000 cycles/ms)
`define SWRT_CFG_RDY_MS    100
`define SWRT_SUCC_MS       1000
`define SWRT_EE_MS         200
`define SWRT_CYC_PER_MS    10000

`endif

// ===== verilog/swrt_mode_dec.v
// swrt_mode_dec.v: decodes the latched switch mode into initial values.
// assumes the mode input is already held stable by the caller.
`timescale 1ns/1ps
`include "swrt_consts.vh"

module swrt_mode_dec (
  input  wire [3:0]  mode_i,
  output reg         normal_o,
  output reg         multi_o,
  output reg         ee_o,
  output reg  [1:0]  part0_st_o,
  output reg  [2:0]  port0_md_o,
  output reg  [2:0]  port2_md_o,
  output reg  [2:0]  other_md_o
);

  // =============================================================
  // mode table; ee pairs share one entry
  always @* begin
    normal_o   = 1'b1;
    multi_o    = 1'b0;
    ee_o       = 1'b0;
    part0_st_o = `SWRT_PST_ACT;
    port0_md_o = `SWRT_PMD_UP;
    port2_md_o = `SWRT_PMD_DOWN;
    other_md_o = `SWRT_PMD_DOWN;
    case (mode_i)
      `SWRT_MD_SP, `SWRT_MD_SP_EE: begin
        ee_o = (mode_i == `SWRT_MD_SP_EE);
      end
      `SWRT_MD_P0U, `SWRT_MD_P0U_EE: begin
        ee_o       = (mode_i == `SWRT_MD_P0U_EE);
        port2_md_o = `SWRT_PMD_DIS;
      end
      `SWRT_MD_P2U, `SWRT_MD_P2U_EE: begin
        ee_o       = (mode_i == `SWRT_MD_P2U_EE);
        port0_md_o = `SWRT_PMD_DIS;
        port2_md_o = `SWRT_PMD_UP;
      end
      `SWRT_MD_MP, `SWRT_MD_MP_EE: begin
        ee_o       = (mode_i == `SWRT_MD_MP_EE);
        multi_o    = 1'b1;
        part0_st_o = `SWRT_PST_DIS;
        port0_md_o = `SWRT_PMD_UNATT;
        port2_md_o = `SWRT_PMD_UNATT;
        other_md_o = `SWRT_PMD_UNATT;
      end
      default: begin
        // test modes keep single-partition values
        normal_o = 1'b0;
      end
    endcase
  end

endmodule // swrt_mode_dec

// ===== test/swrt_chk.sv
// swrt_chk.sv: port assertions for the reset tail sequencer.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`include "swrt_consts.vh"

module swrt_chk #(parameter EE_CYC = 20) (
  input wire        clk_i, srst_i, reg_wr_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        cfg_req_i, cfg_type0_i, cfg_retry_o,
  input wire        cfg_success_o, tlp_drop_o, fc_return_o,
  input wire [15:0] link_retrain_o,
  input wire        normal_op_o, test_mode_o, ee_late_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ====================
  // cycles since release; saturates so long runs never wrap
  reg [15:0] cyc_q;
  always @(posedge clk_i) begin
    if (srst_i)
      cyc_q <= 16'h0000;
    else if (cyc_q != 16'hffff)
      cyc_q <= cyc_q + 16'h0001;
  end

  // ====================
  // sequences and assertions
  sequence s_retrain_wr;
    reg_wr_i && reg_addr_i == `SWRT_OFF_LRETRAIN;
  endsequence
  sequence s_cfg_early;
    cfg_req_i && cfg_type0_i && !normal_op_o;
  endsequence
  a_retrain_now: assert property (
    s_retrain_wr |=> link_retrain_o == $past(reg_wdata_i[15:0]))
    else $error("retrain pulse does not follow write");
  a_retrain_cause: assert property (
    link_retrain_o != 16'h0000 |-> $past(reg_wr_i)
      && $past(reg_addr_i) == `SWRT_OFF_LRETRAIN)
    else $error("retrain pulse without write");
  a_retry_early: assert property (
    s_cfg_early |-> cfg_retry_o && !cfg_success_o)
    else $error("early config request not retried");
  a_success_run: assert property (
    cfg_req_i && normal_op_o |-> cfg_success_o && !cfg_retry_o)
    else $error("config request in run not successful");
  a_no_early_ok: assert property (
    !normal_op_o |-> !cfg_success_o)
    else $error("success before sequence end");
  a_drop_credit: assert property (
    tlp_drop_o |-> cfg_req_i && !cfg_type0_i && fc_return_o)
    else $error("drop without credit return");
  a_run_holds: assert property (
    normal_op_o |=> normal_op_o)
    else $error("left normal operation");
  a_mode_held: assert property (
    cyc_q >= 16'h0002 |-> $stable(test_mode_o))
    else $error("mode class changed after capture");
  a_late_bound: assert property (
    $rose(ee_late_o) |-> cyc_q + 1 >= EE_CYC)
    else $error("late flag before limit");
  a_late_sticky: assert property (
    ee_late_o |=> ee_late_o)
    else $error("late flag not sticky");
endmodule // swrt_chk

bind swrt_tail swrt_chk #(.EE_CYC(EE_CYC)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .cfg_req_i(cfg_req_i), .cfg_type0_i(cfg_type0_i),
  .cfg_retry_o(cfg_retry_o), .cfg_success_o(cfg_success_o),
  .tlp_drop_o(tlp_drop_o), .fc_return_o(fc_return_o),
  .link_retrain_o(link_retrain_o), .normal_op_o(normal_op_o),
  .test_mode_o(test_mode_o), .ee_late_o(ee_late_o));

// ===== test/swrt_agent.sv
// swrt_agent.sv: smbus agent and eeprom loader on the register port.
// assumes callers enter tasks just after a rising clock edge.
`timescale 1ns/1ps
`include "swrt_consts.vh"

module swrt_agent (
  input  wire        clk_i,
  input  wire [31:0] reg_rdata_i,
  output reg  [7:0]  reg_addr_o,
  output reg  [31:0] reg_wdata_o,
  output reg         reg_wr_o,
  output reg         reg_rd_o,
  output reg         ee_done_o,
  output reg         ee_err_o
);
  // idle bus at time zero
  initial begin
    {reg_addr_o, reg_wdata_o} = 40'h0;
    {reg_wr_o, reg_rd_o, ee_done_o, ee_err_o} = 4'h0;
  end

  // released write data and read address flip so stale values never look valid
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
      @(posedge clk_i);
    end
  endtask

  task rd(input [7:0] a, output [31:0] d);
    begin
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(negedge clk_i);
      d = reg_rdata_i;
      @(posedge clk_i);
    end
  endtask

  // image: setup writes first, retrain trigger last
  task ee_load(input err, input [15:0] rt);
    begin
      wr(`SWRT_OFF_PORT_SEL, 32'h3);
      wr(`SWRT_OFF_PORT_CTL, 32'h1);
      wr(`SWRT_OFF_LRETRAIN, {16'h0, rt});
      ee_done_o <= !err;
      ee_err_o <= err;
      @(posedge clk_i);
      {ee_done_o, ee_err_o} <= 2'h0;
    end
  endtask

  // init done: drop halt, leave unlock set for the device
  task release_halt;
    reg [31:0] v;
    begin
      rd(`SWRT_OFF_SWITCH_CONTROL_REG, v);
      if (v[`SWRT_BIT_HALT])
        wr(`SWRT_OFF_SWITCH_CONTROL_REG, 32'h2);
    end
  endtask
endmodule // swrt_agent

// ===== test/swrt_tail_bench.sv
// swrt_tail_bench.sv: self-checking bench for the reset tail.
// assumes swrt_agent drives the register port and eeprom lines.
`timescale 1ns/1ps
`include "swrt_consts.vh"

module swrt_tail_bench;
  reg         clk_i, srst_i, halt, req, t0;
  reg  [3:0]  smode;
  wire [7:0]  ra;
  wire [31:0] wd, rdat;
  wire        wr, rd, eed, eee, rty, ok, drp, fcr, run;
  integer     bad_count, check_count;
  reg  [31:0] v;

  // short eeprom limit keeps the late case brief
  swrt_tail #(.EE_CYC(20)) DUT (.clk_i(clk_i), .srst_i(srst_i),
    .switch_mode_select_i(smode), .boot_halt_i(halt),
    .ee_done_i(eed), .ee_err_i(eee), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .cfg_req_i(req), .cfg_type0_i(t0),
    .cfg_retry_o(rty), .cfg_success_o(ok), .tlp_drop_o(drp),
    .fc_return_o(fcr), .link_retrain_o(), .normal_op_o(run),
    .test_mode_o(), .ee_late_o());
  swrt_agent u_agent (.clk_i(clk_i), .reg_rdata_i(rdat),
    .reg_addr_o(ra), .reg_wdata_o(wd), .reg_wr_o(wr),
    .reg_rd_o(rd), .ee_done_o(eed), .ee_err_o(eee));

  // ====================
  // helpers
  task chk(input [8*6:1] n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        $display("[ERR] %0s exp %h got %h", n, e, g);
        bad_count = bad_count + 1;
      end
    end
  endtask

  // strap moves right after capture to prove it is held
  task boot(input [3:0] m, input h);
    begin
      srst_i <= 1'b1;
      smode <= m;
      halt <= h;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      smode <= ~m;
    end
  endtask

  // expects {retry, success, drop, credit}
  task cfg(input ty, input [3:0] e);
    begin
      req <= 1'b1;
      t0 <= ty;
      @(negedge clk_i);
      chk("cfg", {28'h0, e}, {28'h0, rty, ok, drp, fcr});
      @(posedge clk_i);
      req <= 1'b0;
    end
  endtask

  task wait_run;
    integer i;
    begin
      for (i = 0; i < 40 && run !== 1'b1; i = i + 1)
        @(negedge clk_i);
      chk("run", 32'h1, {31'h0, run});
      @(posedge clk_i);
    end
  endtask

  // {port0, port2, other ports} modes
  function [8:0] exp_md(input [3:0] m);
    case (m)
      4'h0, 4'h1: exp_md = 9'h089;
      4'h8, 4'ha: exp_md = 9'h081;
      4'h9, 4'hb: exp_md = 9'h011;
      default:    exp_md = 9'h16d;
    endcase
  endfunction

  // ====================
  // scenarios
  task t_modes;
    reg [3:0] m;
    reg [8:0] x;
    reg       mp, ee;
    integer   i, p;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        m = (i < 2) ? i[3:0] : i[3:0] + 4'h6;
        x = exp_md(m);
        mp = m[3] & m[2];
        ee = (m == 4'h1) || (m == 4'ha) || (m == 4'hb) || (m == 4'hd);
        boot(m, 1'b0);
        if (ee) begin
          cfg(1'b0, 4'h8);
          u_agent.ee_load(1'b0, 16'h0001 << i);
        end
        wait_run;
        cfg(1'b1, 4'h4);
        u_agent.rd(`SWRT_OFF_STATUS, v);
        chk("status", {mp, ee, m}, {v[12:9], v[3:0]});
        for (p = 0; p < 3; p = p + 1) begin
          u_agent.wr(`SWRT_OFF_PORT_SEL, p);
          u_agent.rd(`SWRT_OFF_PORT_CTL, v);
          chk("port", p == 0 ? x[8:6] : p == 2 ? x[5:3] : x[2:0],
              v[2:0]);
        end
        u_agent.rd(`SWRT_OFF_PART_CTL, v);
        chk("part0", !mp, v[1:0]);
        u_agent.wr(`SWRT_OFF_PART_SEL, 32'h1);
        u_agent.rd(`SWRT_OFF_PART_CTL, v);
        chk("part1", 32'h0, v[1:0]);
        u_agent.wr(`SWRT_OFF_PART_CTL, 32'h1);
        u_agent.rd(`SWRT_OFF_PART_CTL, v);
        chk("part1w", mp, v[1:0]);
      end
    end
  endtask

  // unlock left set by the agent must be cleared on release
  task t_halt;
    begin
      boot(4'h2, 1'b0);
      u_agent.rd(`SWRT_OFF_STATUS, v);
      chk("test", 32'h1, v[11]);
      boot(4'h0, 1'b1);
      repeat (3) @(posedge clk_i);
      cfg(1'b1, 4'h8);
      cfg(1'b0, 4'h3);
      u_agent.rd(`SWRT_OFF_SWITCH_CONTROL_REG, v);
      chk("halt", 32'h1, v[0]);
      u_agent.release_halt;
      wait_run;
      u_agent.rd(`SWRT_OFF_SWITCH_CONTROL_REG, v);
      chk("switch_control_reg", 32'h0, v[1:0]);
    end
  endtask

  // loader stalls past the limit, then ends in error
  task t_ee_err;
    begin
      boot(4'h1, 1'b0);
      repeat (24) @(posedge clk_i);
      u_agent.rd(`SWRT_OFF_STATUS, v);
      chk("late", 32'h1, v[12]);
      u_agent.ee_load(1'b1, 16'h8000);
      u_agent.rd(`SWRT_OFF_SWITCH_CONTROL_REG, v);
      chk("errhlt", 32'h1, v[0]);
      u_agent.release_halt;
      wait_run;
    end
  endtask

  // ====================
  // verdict, clock, main sequence and watchdog
  task complete_run;
    begin
      if (bad_count == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    {srst_i, halt, req, t0, smode} = 8'h80;
    bad_count = 0;
    check_count = 0;
    @(posedge clk_i);
    t_modes;
    t_halt;
    t_ee_err;
    complete_run;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule // swrt_tail_bench
